// File: sep_top.sv
// Serial EEPROM slave front end: pin sampling, command framing, hold, status and protection.
// Assumes all spi_* pins are asynchronous to clk_i and sclk runs well below a quarter of clk_i;
// rd_data_i answers rd_addr_o from same-clock logic; write bytes leave via wr_valid_o/wr_ready_i.
//
// Contract
// R1: Output bits MSB first, updated on sclk falling edges, driven only while reading.
// R2: Input bits sampled on sclk rising edges, MSB first.
// R3: Select high deselects and releases the output at once.
// R4: Standby only when deselected and no internal write cycle runs.
// R5: Master uses mode 0 or 3; rising samples, falling presents, either way.
// R6: Hold low with sclk low pauses; output released, edges ignored.
// R7: Pause ends when hold high and sclk low; sequence resumes.
// R8: Deselect while paused abandons the transaction, back to idle; code still commits a frame paused on a byte boundary.
// R9: After power-up a low select is ignored until a falling edge.
// R10: Write needs latch set, select low throughout, whole bytes, one data byte.
// R11: Select rising off a byte boundary discards a write command.
// R12: Read commands keep shifting data out until select rises.
// R13: Status bits six, five and four always read zero.
// R14: Busy flag is one from write decode until its cycle completes.
// R15: Write command runs only with the enable latch at one.
// R16: Latch set by enable, cleared by disable, write completion, power-up.
// R17: Block-protect bits change only by status write when not locked.
// R18: Protect codes: none, 600h-7FFh, 400h-7FFh, everything.
// R19: Write-disable bit zero allows status writes at any protect pin level.
// R20: Write-disable one with protect pin low discards status writes.
// R21: Lock arises in either order, left only by raising the protect pin.
// R22: Array is 2048 bytes as 64 pages of 32 bytes.
// R23: Status bits take new values only after the write cycle completes.
// R24: Unknown instruction waits, ignoring activity until select rises.
// R25: Status write during a running write cycle is rejected.
// R26: Status layout: busy bit 0, latch bit 1, protect bits 2-3, disable bit 7.
// R27: Write cycle length is a configurable count of clocks with busy set.
`timescale 1ns/1ps

module sep_fifo #(
    parameter int WIDTH = 19,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_i,
    input  wire logic             resetn_i,
    input  wire logic             flush_i,
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    output logic                  out_valid_o,
    output logic      [WIDTH-1:0] out_data_o,
    input  wire logic             out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } sep_fifo_state_type;

    sep_fifo_state_type r;
    sep_fifo_state_type n;
    logic push;
    logic pop;

    always_comb begin
        n = r;
        push = in_valid_i && (r.cnt != FULL_CNT);
        pop = out_ready_i && (r.cnt != '0);
        if (flush_i) begin
            n.wp = '0;
            n.rp = '0;
            n.cnt = '0;
        end else begin
            if (push) begin
                n.mem[r.wp] = in_data_i;
                n.wp = r.wp + 1'h1;
            end
            if (pop) begin
                n.rp = r.rp + 1'h1;
            end
            n.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign in_ready_o = (r.cnt != FULL_CNT);
    assign out_valid_o = (r.cnt != '0);
    assign out_data_o = r.mem[r.rp];
endmodule : sep_fifo

module sep_top #(
    parameter int unsigned WRITE_CYCLES = (`SEP_TW_NS * `SEP_CLK_MHZ) / `SEP_NS_PER_US
) (
    input  wire logic                          clk_i,
    input  wire logic                          resetn_i,
    input  wire logic                          spi_sclk_i,
    input  wire logic                          spi_cs_n_i,
    input  wire logic                          spi_mosi_i,
    input  wire logic                          spi_hold_n_i,
    input  wire logic                          spi_wp_n_i,
    output logic                               spi_miso_o,
    output logic                               spi_miso_oe_n_o,
    output logic [`SEP_ADDR_W-1:0]             rd_addr_o,
    input  wire logic [7:0]                    rd_data_i,
    output logic                               wr_valid_o,
    output sep_pkg::sep_wr_entry_type          wr_entry_o,
    input  wire logic                          wr_ready_i,
    output logic                               standby_o
);
    import sep_pkg::*;

    localparam logic [`SEP_CYC_W-1:0] CYC_LOAD = `SEP_CYC_W'(WRITE_CYCLES - 1);
    localparam int ENTRY_W = $bits(sep_wr_entry_type);

    sep_state_type    r;
    sep_state_type    n;
    logic             sclk_rise;
    logic             sclk_fall;
    logic             cs_fall;
    logic             boundary;
    logic             sr_locked;
    logic             wel_set;
    logic             prot;
    logic [7:0]       byte_in;
    logic [7:0]       out_byte;
    logic [7:0]       status_byte;
    logic             fifo_push;
    logic             fifo_flush;
    logic             fifo_in_ready;
    logic             fifo_out_valid;
    logic             fifo_pop;
    sep_wr_entry_type fifo_out_data;
    sep_wr_entry_type push_entry;

    always_comb begin
        n = r;
        fifo_push = 1'h0;
        fifo_flush = 1'h0;
        wel_set = 1'h0;
        push_entry = '0;
        out_byte = r.sh_out;
        // Bit [0] of each vector is the metastable stage, read only by bit [1]
        n.sclk = {r.sclk[1:0], spi_sclk_i};
        n.cs = {r.cs[1:0], spi_cs_n_i};
        n.mosi = {r.mosi[0], spi_mosi_i};
        n.hold = {r.hold[0], spi_hold_n_i};
        n.wp = {r.wp[0], spi_wp_n_i};
        sclk_rise = r.sclk[1] && !r.sclk[2]; // [R5]
        sclk_fall = !r.sclk[1] && r.sclk[2]; // [R5]
        cs_fall = !r.cs[1] && r.cs[2];
        boundary = (r.bit_cnt == `SEP_FIRST_BIT);
        byte_in = {r.sh_in[6:0], r.mosi[1]};
        sr_locked = r.swd && !r.wp[1]; // [R19] [R20] [R21]

        status_byte = 8'h00; // [R13]
        status_byte[`SEP_SR_BUSY] = r.busy; // [R26] [R14]
        status_byte[`SEP_SR_WEL] = r.write_enable_latch; // [R26]
        status_byte[`SEP_SR_BP_LO] = r.bp[0]; // [R26]
        status_byte[`SEP_SR_BP_HI] = r.bp[1]; // [R26]
        status_byte[`SEP_SR_SWD] = r.swd; // [R26]

        case (r.bp) // [R18]
            `SEP_BP_NONE:    prot = 1'h0;
            `SEP_BP_QUARTER: prot = (r.addr >= `SEP_QUARTER_BASE);
            `SEP_BP_HALF:    prot = (r.addr >= `SEP_HALF_BASE);
            default:         prot = 1'h1;
        endcase

        // Select high held once is what arms the device after reset
        if (r.cs[1]) begin
            n.armed = 1'h1; // [R9]
        end

        if (!r.sel) begin
            if (cs_fall && r.armed) begin // [R9]
                n.sel = 1'h1;
                n.phase = ph_cmd;
                n.bit_cnt = `SEP_FIRST_BIT;
                n.got_data = 1'h0;
                n.ovf = 1'h0;
                n.reading = 1'h0;
                n.paused = 1'h0;
            end
        end else if (r.cs[1]) begin
            // Deselect: commit or drop, then back to idle even if paused [R3] [R8]
            // A status read during a drain must not lose buffered bytes
            fifo_flush = !r.drain;
            case (r.phase)
                ph_short: begin
                    if (boundary && r.cmd == `SEP_OP_ENABLE_WRITES) begin
                        n.write_enable_latch = 1'h1; // [R16]
                        wel_set = 1'h1;
                    end
                    if (boundary && r.cmd == `SEP_OP_DISABLE_WRITES) begin
                        n.write_enable_latch = 1'h0; // [R16]
                    end
                end
                ph_wdata: begin
                    // Whole bytes, a data byte, latch set, device idle [R10] [R11] [R15] [R25]
                    if (boundary && r.got_data && r.write_enable_latch && !r.busy) begin
                        if (r.cmd == `SEP_OP_STATUS_WRITE) begin
                            if (!sr_locked && !r.ovf) begin // [R17] [R20] [R25]
                                n.busy = 1'h1; // [R14]
                                n.kind_sr = 1'h1;
                                n.drain = 1'h0;
                                n.cyc_cnt = CYC_LOAD; // [R27]
                            end
                        end else if (!r.ovf) begin
                            n.busy = 1'h1; // [R14]
                            n.kind_sr = 1'h0;
                            n.drain = 1'h1;
                            fifo_flush = 1'h0;
                        end
                    end
                end
                default: begin
                end
            endcase
            n.sel = 1'h0;
            n.phase = ph_idle;
            n.paused = 1'h0; // [R8]
            n.reading = 1'h0;
        end else if (!r.paused && !r.hold[1] && !r.sclk[1]) begin
            n.paused = 1'h1; // [R6]
        end else if (r.paused) begin
            // Edges seen while paused are dropped; sclk history still advances
            if (r.hold[1] && !r.sclk[1]) begin
                n.paused = 1'h0; // [R7]
            end
        end else begin
            if (sclk_rise && r.phase != ph_wait) begin // [R2] [R24]
                n.sh_in = byte_in;
                n.bit_cnt = 3'(r.bit_cnt + 3'h1);
                if (r.phase == ph_short) begin
                    n.phase = ph_wait;
                end else if (r.bit_cnt == `SEP_LAST_BIT) begin
                    case (r.phase)
                        ph_cmd: begin
                            n.cmd = byte_in;
                            case (byte_in)
                                `SEP_OP_ENABLE_WRITES:  n.phase = ph_short;
                                `SEP_OP_DISABLE_WRITES: n.phase = ph_short;
                                `SEP_OP_STATUS_READ:    n.phase = ph_rdata;
                                `SEP_OP_STATUS_WRITE:   n.phase = ph_wdata;
                                `SEP_OP_ARRAY_READ:     n.phase = ph_addr_hi;
                                `SEP_OP_ARRAY_WRITE:    n.phase = ph_addr_hi;
                                default:                n.phase = ph_wait; // [R24]
                            endcase
                        end
                        ph_addr_hi: begin
                            // Upper five address bits are don't care [R22]
                            n.addr[`SEP_ADDR_W-1:8] = byte_in[`SEP_HI_ADDR_W-1:0];
                            n.phase = ph_addr_lo;
                        end
                        ph_addr_lo: begin
                            n.addr[7:0] = byte_in;
                            n.phase = (r.cmd == `SEP_OP_ARRAY_READ) ? ph_rdata : ph_wdata;
                        end
                        ph_wdata: begin
                            n.got_data = 1'h1; // [R10]
                            if (r.cmd == `SEP_OP_STATUS_WRITE) begin
                                if (r.busy) begin
                                    n.ovf = 1'h1; // [R25]
                                end else if (!r.got_data) begin
                                    // Held until the cycle ends [R23]
                                    n.sr_pend = {byte_in[`SEP_SR_SWD], byte_in[`SEP_SR_BP_HI], byte_in[`SEP_SR_BP_LO]};
                                end
                            end else begin
                                // Protected bytes never reach the buffer [R18]
                                push_entry.addr = r.addr;
                                push_entry.data = byte_in;
                                // Bytes of a refused frame would mix with the drain
                                fifo_push = !prot && !r.busy;
                                if (fifo_push && !fifo_in_ready) begin
                                    n.ovf = 1'h1;
                                end
                                // Address wraps within its 32-byte page [R22]
                                n.addr[`SEP_PAGE_W-1:0] = r.addr[`SEP_PAGE_W-1:0] + `SEP_PAGE_W'(1);
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
            if (sclk_fall && r.phase == ph_rdata) begin // [R1] [R12]
                if (boundary) begin
                    if (r.cmd == `SEP_OP_STATUS_READ) begin
                        out_byte = status_byte; // [R13]
                    end else begin
                        out_byte = rd_data_i;
                        n.addr = r.addr + `SEP_ADDR_W'(1); // [R22]
                    end
                end
                n.miso = out_byte[7]; // [R1]
                n.sh_out = {out_byte[6:0], 1'h0};
                n.reading = 1'h1;
            end
        end

        // Buffered bytes go out only after a committed command
        fifo_pop = r.drain && (!r.wr_valid || wr_ready_i);
        if (r.wr_valid && wr_ready_i) begin
            n.wr_valid = 1'h0;
        end
        if (fifo_pop) begin
            n.wr_valid = fifo_out_valid;
            n.wr_entry = fifo_out_data;
        end

        if (r.busy) begin
            if (r.drain) begin
                if (!fifo_out_valid && !r.wr_valid) begin
                    n.drain = 1'h0;
                    n.cyc_cnt = CYC_LOAD; // [R27]
                end
            end else if (r.cyc_cnt != '0) begin
                n.cyc_cnt = r.cyc_cnt - `SEP_CYC_W'(1); // [R27]
            end else begin
                n.busy = 1'h0; // [R14]
                n.write_enable_latch = wel_set; // [R16] an enable in this cycle wins
                if (r.kind_sr) begin
                    n.swd = r.sr_pend[2]; // [R23] [R17]
                    n.bp = r.sr_pend[1:0]; // [R23] [R17]
                end
            end
        end

        n.miso_oe_n = !(n.sel && n.reading && !n.paused); // [R1] [R3] [R6]
        n.standby = !n.sel && !n.busy; // [R4]
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            r <= '0;
            r.miso_oe_n <= 1'h1;
            r.standby <= 1'h1;
            r.bp <= `SEP_BP_RESET;
            r.swd <= `SEP_SWD_RESET;
        end else begin
            r <= n;
        end
    end

    sep_fifo #(
        .WIDTH (ENTRY_W),
        .DEPTH (`SEP_FIFO_DEPTH)
    ) u_wr_fifo (
        .clk_i       (clk_i),
        .resetn_i    (resetn_i),
        .flush_i     (fifo_flush),
        .in_valid_i  (fifo_push),
        .in_data_i   (push_entry),
        .in_ready_o  (fifo_in_ready),
        .out_valid_o (fifo_out_valid),
        .out_data_o  (fifo_out_data),
        .out_ready_i (fifo_pop)
    );

    assign spi_miso_o = r.miso;
    assign spi_miso_oe_n_o = r.miso_oe_n;
    assign rd_addr_o = r.addr;
    assign wr_valid_o = r.wr_valid;
    assign wr_entry_o = r.wr_entry;
    assign standby_o = r.standby;
endmodule : sep_top

// File: sep_params.svh
// Constants for the serial EEPROM front end: opcodes, status layout, protection bounds, timing.
// Assumes inclusion by the package and the design file only.
`ifndef SEP_PARAMS_SVH
`define SEP_PARAMS_SVH

`define SEP_OP_ENABLE_WRITES  8'h06
`define SEP_OP_DISABLE_WRITES 8'h04
`define SEP_OP_STATUS_READ    8'h05
`define SEP_OP_STATUS_WRITE   8'h01
`define SEP_OP_ARRAY_READ     8'h03
`define SEP_OP_ARRAY_WRITE    8'h02

`define SEP_SR_BUSY           0
`define SEP_SR_WEL            1
`define SEP_SR_BP_LO          2
`define SEP_SR_BP_HI          3
`define SEP_SR_SWD            7

`define SEP_BP_RESET          2'h0
`define SEP_SWD_RESET         1'h0
`define SEP_BP_NONE           2'h0
`define SEP_BP_QUARTER        2'h1
`define SEP_BP_HALF           2'h2
`define SEP_BP_ALL            2'h3
`define SEP_QUARTER_BASE      11'h600
`define SEP_HALF_BASE         11'h400

`define SEP_ADDR_W            11
`define SEP_PAGE_W            5
`define SEP_HI_ADDR_W         3
`define SEP_LAST_BIT          3'h7
`define SEP_FIRST_BIT         3'h0
`define SEP_FIFO_DEPTH        16
`define SEP_CYC_W             18

`define SEP_TW_NS             4000000
`define SEP_CLK_MHZ           40
`define SEP_NS_PER_US         1000

`endif

// File: sep_pkg.sv
// Types shared by the serial EEPROM front end and its write buffer.
// Assumes sep_params.svh sits in the include path.
`include "sep_params.svh"

package sep_pkg;

    typedef enum logic [2:0] {
        ph_idle    = 3'b000,
        ph_cmd     = 3'b001,
        ph_addr_hi = 3'b010,
        ph_addr_lo = 3'b011,
        ph_wdata   = 3'b100,
        ph_rdata   = 3'b101,
        ph_short   = 3'b110,
        ph_wait    = 3'b111
    } sep_phase_type;

    typedef struct packed {
        logic [`SEP_ADDR_W-1:0] addr;
        logic [7:0]             data;
    } sep_wr_entry_type;

    typedef struct packed {
        logic [2:0]             sclk;
        logic [2:0]             cs;
        logic [1:0]             mosi;
        logic [1:0]             hold;
        logic [1:0]             wp;
        sep_phase_type          phase;
        logic                   armed;
        logic                   sel;
        logic                   paused;
        logic                   reading;
        logic [2:0]             bit_cnt;
        logic [7:0]             sh_in;
        logic [7:0]             sh_out;
        logic [7:0]             cmd;
        logic [`SEP_ADDR_W-1:0] addr;
        logic                   got_data;
        logic                   ovf;
        logic                   write_enable_latch;
        logic                   swd;
        logic [1:0]             bp;
        logic [2:0]             sr_pend;
        logic                   busy;
        logic                   kind_sr;
        logic                   drain;
        logic [`SEP_CYC_W-1:0]  cyc_cnt;
        logic                   miso;
        logic                   miso_oe_n;
        logic                   standby;
        logic                   wr_valid;
        sep_wr_entry_type       wr_entry;
    } sep_state_type;

endpackage : sep_pkg

// File: sep_chk.sv
// Port-level assertions for the serial EEPROM front end.
// Assumes it is bound into sep_top; every pin is sampled on clk_i.
`timescale 1ns/1ps
module sep_chk #(
    parameter int unsigned WRITE_CYCLES = 20
) (
    input wire logic                      clk_i,
    input wire logic                      resetn_i,
    input wire logic                      spi_sclk_i,
    input wire logic                      spi_cs_n_i,
    input wire logic                      spi_hold_n_i,
    input wire logic                      spi_miso_o,
    input wire logic                      spi_miso_oe_n_o,
    input wire logic                      wr_valid_o,
    input wire sep_pkg::sep_wr_entry_type wr_entry_o,
    input wire logic                      wr_ready_i,
    input wire logic                      standby_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    property p_rel; $rose(spi_cs_n_i) |-> ##[1:8] spi_miso_oe_n_o; endproperty
    a_rel: assert property (p_rel) else $error("output kept after deselect");
    property p_idle; spi_cs_n_i [*8] |-> spi_miso_oe_n_o; endproperty
    a_idle: assert property (p_idle) else $error("output driven while deselected");
    // Output may only move near a falling serial clock edge
    property p_hi; (spi_sclk_i && !spi_miso_oe_n_o) [*4] |-> $stable(spi_miso_o); endproperty
    a_hi: assert property (p_hi) else $error("output moved while clock high");
    property p_act; $fell(spi_cs_n_i) ##1 !spi_cs_n_i [*5] |-> !standby_o; endproperty
    a_act: assert property (p_act) else $error("standby while selected");
    property p_busy; wr_valid_o [*2] |-> !standby_o; endproperty
    a_busy: assert property (p_busy) else $error("standby during write drain");
    property p_pause; (!spi_hold_n_i && !spi_sclk_i) [*8] |-> spi_miso_oe_n_o; endproperty
    a_pause: assert property (p_pause) else $error("output driven in pause");
    property p_hold; wr_valid_o && !wr_ready_i |=> wr_valid_o && $stable(wr_entry_o); endproperty
    a_hold: assert property (p_hold) else $error("write entry dropped");
    property p_commit; $rose(wr_valid_o) |-> $past(spi_cs_n_i, 2); endproperty
    a_commit: assert property (p_commit) else $error("write before deselect");
    property p_drive; $fell(spi_miso_oe_n_o) |-> !$past(spi_cs_n_i, 2); endproperty
    a_drive: assert property (p_drive) else $error("output driven unselected");
endmodule : sep_chk

bind sep_top sep_chk #(.WRITE_CYCLES(WRITE_CYCLES)) sep_chk_inst (
    .clk_i(clk_i), .resetn_i(resetn_i), .spi_sclk_i(spi_sclk_i), .spi_cs_n_i(spi_cs_n_i),
    .spi_hold_n_i(spi_hold_n_i), .spi_miso_o(spi_miso_o), .spi_miso_oe_n_o(spi_miso_oe_n_o),
    .wr_valid_o(wr_valid_o), .wr_entry_o(wr_entry_o), .wr_ready_i(wr_ready_i), .standby_o(standby_o)
);

// File: sep_master.sv
// Bus master model driving the serial pins in clock mode 0 or 3.
// Assumes clk_i is the bench clock; half a serial period is four clk_i periods.
`timescale 1ns/1ps
module sep_master (
    input  wire logic clk_i,
    input  wire logic miso_i,
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      mosi_o,
    output logic      hold_n_o
);
    bit mode3 = 1'b0;
    // Select low from power-up to probe the select guard
    initial begin
        sclk_o   = 1'b0;
        cs_n_o   = 1'b0;
        mosi_o   = 1'b0;
        hold_n_o = 1'b1;
    end
    task automatic half();
        repeat (4) @(posedge clk_i);
    endtask : half
    // Sends tx[n-1:0]; pauses before bit hb rises, ab drops select in the pause
    task automatic frame(input logic [159:0] tx, input int n, input int hb, input bit ab,
                         output logic [31:0] rx);
        rx = '0;
        sclk_o <= mode3;
        half();
        cs_n_o <= 1'b0;
        half();
        for (int i = n - 1; i >= 0; i--) begin
            sclk_o <= 1'b0;
            mosi_o <= tx[i];
            half();
            if (i == hb) begin
                hold_n_o <= 1'b0;
                repeat (10) @(posedge clk_i);
                sclk_o <= 1'b1;
                half();
                sclk_o <= 1'b0;
                half();
                if (ab) begin
                    cs_n_o <= 1'b1;
                    half();
                end
                hold_n_o <= 1'b1;
                half();
                if (ab) return;
            end
            sclk_o <= 1'b1;
            half();
            rx = {rx[30:0], miso_i};
        end
        sclk_o <= mode3;
        half();
        cs_n_o <= 1'b1;
        mosi_o <= ~mosi_o;
        half();
        half();
    endtask : frame
endmodule : sep_master

// File: tb_top.sv
// Self-checking bench: status and write-stream model compared with the front end.
// Assumes sep_master drives the serial pins; array bytes follow an address pattern.
`timescale 1ns/1ps
module tb_top;
    import sep_pkg::*;
    localparam int unsigned WC = 600;
    logic             clk_i    = 1'b0;
    logic             resetn_i = 1'b0;
    logic             wp_n     = 1'b1;
    logic             wr_ready = 1'b0;
    logic             stall    = 1'b0;
    logic             sclk, cs_n, mosi, hold_n, miso, oe_n, wr_valid, standby;
    logic [10:0]      rd_addr;
    sep_wr_entry_type wr_entry;
    sep_wr_entry_type got_q[$];
    sep_wr_entry_type exp_q[$];
    int               n_fail = 0;
    int               num_checks = 0;
    int               write_enable_latch = 0, bp = 0, swd = 0;
    logic [31:0]      rx;
    wire logic [7:0]  rd_data = rd_addr[7:0] ^ 8'hC3;
    wire logic        miso_bus = oe_n ? 1'b1 : miso; // Released line reads as pulled up

    sep_top #(.WRITE_CYCLES(WC)) sep_top_inst (
        .clk_i(clk_i), .resetn_i(resetn_i), .spi_sclk_i(sclk), .spi_cs_n_i(cs_n), .spi_mosi_i(mosi),
        .spi_hold_n_i(hold_n), .spi_wp_n_i(wp_n), .spi_miso_o(miso), .spi_miso_oe_n_o(oe_n),
        .rd_addr_o(rd_addr), .rd_data_i(rd_data), .wr_valid_o(wr_valid), .wr_entry_o(wr_entry),
        .wr_ready_i(wr_ready), .standby_o(standby)
    );
    sep_master sep_master_inst (
        .clk_i(clk_i), .miso_i(miso_bus), .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .hold_n_o(hold_n)
    );

    always #12.5 clk_i = ~clk_i;

    always @(posedge clk_i) begin
        wr_ready <= stall ? 1'b0 : 1'($urandom % 2);
        if (wr_valid && wr_ready) got_q.push_back(wr_entry);
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [18:0] got, input logic [18:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic op(input logic [159:0] v, input int n);
        sep_master_inst.frame(v, n, -1, 1'b0, rx);
    endtask : op

    task automatic st(input logic busy, input int hb = -1);
        sep_master_inst.frame(16'h0500, 16, hb, 1'b0, rx);
        chk({11'h000, rx[7:0]}, {11'h000, swd[0], 3'h0, bp[1:0], write_enable_latch[0], busy});
    endtask : st

    task automatic en();
        op(8'h06, 8);
        write_enable_latch = 1;
    endtask : en

    task automatic dis();
        op(8'h04, 8);
        write_enable_latch = 0;
    endtask : dis

    // Bounded poll of the busy flag; completion clears the latch
    task automatic ready();
        for (int k = 0; k < 20; k++) begin
            op(16'h0500, 16);
            if (rx[0] === 1'b0) break;
        end
        write_enable_latch = 0;
    endtask : ready

    task automatic wr(input logic [10:0] a, input int nb, input bit cut);
        logic [159:0] tx;
        logic [7:0]   b;
        logic [10:0]  ad;
        tx = {8'h02, 5'h00, a};
        for (int k = 0; k < nb; k++) begin
            b = 8'($urandom);
            ad = {a[10:5], a[4:0] + 5'(k)};
            tx = {tx[151:0], b};
            if (!cut && !(bp == 3 || (bp == 2 && ad >= 11'h400) || (bp == 1 && ad >= 11'h600)))
                exp_q.push_back({ad, b});
        end
        if (cut) tx = {tx[156:0], 3'h5};
        en();
        op(tx, 24 + 8 * nb + (cut ? 3 : 0));
        repeat (40) @(posedge clk_i);
        stall <= 1'b0;
    endtask : wr

    initial begin
        void'($urandom(32'hCD9366CB));
        repeat (10) @(posedge clk_i);
        resetn_i <= 1'b1;
        op(8'h06, 8);
        st(1'b0);
        for (int m = 0; m < 2; m++) begin
            sep_master_inst.mode3 = m[0];
            en();
            st(1'b0);
            dis();
            st(1'b0);
        end
        sep_master_inst.mode3 = 1'b0;
        op(9'h00C, 9);
        st(1'b0);
        op(16'h018C, 16);
        st(1'b0);
        en();
        op(16'h01FC, 16);
        st(1'b1);
        chk(19'(standby), 19'h0);
        op(16'h0100, 16);
        ready();
        swd = 1;
        bp = 3;
        st(1'b0);
        wp_n <= 1'b0;
        en();
        op(16'h0100, 16);
        st(1'b0);
        wp_n <= 1'b1;
        op(16'h0100, 16);
        ready();
        swd = 0;
        bp = 0;
        st(1'b0);
        wp_n <= 1'b0;
        en();
        op(16'h0104, 16);
        ready();
        bp = 1;
        st(1'b0);
        wr(11'h5FE, 3, 1'b0);
        ready();
        wr(11'h600, 2, 1'b0);
        ready();
        dis();
        wr(11'h010, 1, 1'b1);
        dis();
        stall <= 1'b1;
        wr(11'h01C, 16, 1'b0);
        ready();
        chk(19'(standby), 19'h1);
        st(1'b0);
        chk(19'(got_q.size()), 19'(exp_q.size()));
        foreach (exp_q[i]) chk(got_q[i], exp_q[i]);
        op(40'h0307FF0000, 40);
        chk({3'h0, rx[15:0]}, {3'h0, 8'hFF ^ 8'hC3, 8'h00 ^ 8'hC3});
        st(1'b0, 5);
        sep_master_inst.frame(8'h06, 8, 3, 1'b1, rx);
        st(1'b0);
        op(16'h8306, 16);
        st(1'b0);
        end_of_test();
    end

    // Whole sequence needs roughly 12000 cycles; allow five times that
    initial begin
        repeat (60000) @(posedge clk_i);
        n_fail++;
        end_of_test();
    end
endmodule : tb_top
